/* File: design/gain_switch_pkg.sv */
// gain_switch_pkg: constants, register map and carriers of the gain set selector
// assumes one 125 MHz control clock and a plain word-addressed register port
package gain_switch_pkg;
	// clock and control cycle timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int CTRL_PERIOD_NS = 125000;
	localparam int NS_PER_MS = 1000000;
	// widths and counts
	localparam int GW = 16;
	localparam int NGAIN = 13;
	localparam int NSET = 3;
	localparam int DW = 32;
	localparam int CNTW = 24;
	typedef logic [GW-1:0] gain_t;
	typedef logic signed [15:0] qty_t;
	typedef logic [15:0] thr_t;
	typedef gain_t [NGAIN-1:0] gain_set_t;
	typedef enum logic [1:0] {
		SET_BASE = 2'b00,
		SET_SW1 = 2'b01,
		SET_SW2 = 2'b10
	} set_t;
	// first switch source codes
	localparam logic [3:0] SRC1_OFF = 4'h0;
	localparam logic [3:0] SRC1_SIG = 4'h1;
	localparam logic [3:0] SRC1_FREQ = 4'h2;
	localparam logic [3:0] SRC1_DROOP = 4'h3;
	localparam logic [3:0] SRC1_SPEED = 4'h4;
	localparam logic [3:0] SRC1_DIR = 4'h5;
	// second switch source codes
	localparam logic [3:0] SRC2_OFF = 4'h0;
	localparam logic [3:0] SRC2_SIG = 4'h1;
	localparam logic [3:0] SRC2_SAME = 4'h2;
	// time constant disable codes
	localparam logic [3:0] TCD_ON = 4'h0;
	localparam logic [3:0] TCD_AT_SWITCH = 4'h1;
	localparam logic [3:0] TCD_AT_RETURN = 4'h2;
	// configuration word, one hex digit per field
	typedef struct packed {
		logic [3:0] switch2_source_select;
		logic [3:0] spare;
		logic [3:0] time_constant_disable_select;
		logic [3:0] switch_condition_polarity;
		logic [3:0] switch1_source_select;
	} cfg_t;
	// monitored quantities of the control loop
	typedef struct packed {
		qty_t cmd_freq;
		qty_t droop;
		qty_t speed;
		logic dir_neg;
		logic dir_pos;
	} monitor_t;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	// register word addresses and reset values
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_THR1 = 8'h01;
	localparam logic [7:0] ADDR_THR2 = 8'h02;
	localparam logic [7:0] ADDR_TC1 = 8'h03;
	localparam logic [7:0] ADDR_TC2 = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h05;
	localparam logic [7:0] ADDR_STATUS = 8'h06;
	localparam logic [7:0] ADDR_GAIN = 8'h10;
	localparam logic [3:0] GAIN_SET_NIB = 4'h1;
	localparam cfg_t CFG_RST = 20'h00000;
	localparam thr_t THR_RST = 16'h0000;
	localparam logic [15:0] TC_RST = 16'h0000;
	localparam gain_t GAIN_RST = 16'h0000;
	// magnitude of a signed monitored quantity
	function automatic logic [15:0] qty_mag(qty_t v);
		qty_mag = v[15] ? 16'(-v) : 16'(v);
	endfunction : qty_mag
endpackage : gain_switch_pkg

/* File: design/switch_condition_eval.sv */
// switch_condition_eval: decides base, first or second switched gain set
// assumes inputs already registered or stable within one control cycle
`timescale 1ns/100ps
module switch_condition_eval (
	input gain_switch_pkg::cfg_t cfg,
	input gain_switch_pkg::thr_t thr1,
	input gain_switch_pkg::thr_t thr2,
	input gain_switch_pkg::monitor_t mon,
	input logic sig1,
	input logic sig2,
	output gain_switch_pkg::set_t sel
);
	import gain_switch_pkg::*;
	logic [15:0] mag;
	logic pol, hit1, hit2, dir, c1, c2;
	// magnitude in native units of the selected quantity
	always_comb begin
		case (cfg.switch1_source_select)
			SRC1_FREQ: mag = qty_mag(mon.cmd_freq);
			SRC1_DROOP: mag = qty_mag(mon.droop);
			SRC1_SPEED: mag = qty_mag(mon.speed);
			default: mag = 16'h0000;
		endcase
		pol = cfg.switch_condition_polarity[0];
		hit1 = pol ? (mag <= thr1) : (mag >= thr1);
		hit2 = pol ? (mag <= thr2) : (mag >= thr2);
		dir = pol ? mon.dir_pos : mon.dir_neg;
		case (cfg.switch1_source_select)
			SRC1_SIG: c1 = sig1 ^ pol;
			SRC1_FREQ, SRC1_DROOP, SRC1_SPEED: c1 = hit1;
			SRC1_DIR: c1 = dir;
			default: c1 = 1'b0;
		endcase
		case (cfg.switch2_source_select)
			SRC2_SIG: c2 = sig2;
			SRC2_SAME: begin
				if (cfg.switch1_source_select == SRC1_SIG) c2 = sig2;
				else if (thr2 == 16'h0000) c2 = 1'b0;
				else if (cfg.switch1_source_select == SRC1_DIR) c2 = dir;
				else if (cfg.switch1_source_select inside {SRC1_FREQ, SRC1_DROOP, SRC1_SPEED})
					c2 = hit2;
				else c2 = 1'b0;
			end
			default: c2 = 1'b0;
		endcase
		// second set wins when both hold, base when none holds
		sel = c2 ? SET_SW2 : (c1 ? SET_SW1 : SET_BASE);
	end
endmodule : switch_condition_eval

/* File: design/gain_lag_filter.sv */
// gain_lag_filter: first-order lag on one gain, power-of-two step per control tick
// assumes tick is a one-cycle pulse once per control cycle
`timescale 1ns/100ps
module gain_lag_filter (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic tick,
	input gain_switch_pkg::gain_t target,
	input wire logic [4:0] shift,
	input wire logic bypass,
	output gain_switch_pkg::gain_t level
);
	import gain_switch_pkg::*;
	typedef struct packed {
		logic [31:0] acc;
	} lag_state_t;
	lag_state_t q, d;
	logic signed [32:0] diff;
	// move a fraction of the gap toward the target each tick
	always_comb begin
		d = q;
		diff = $signed({1'b0, target, 16'h0000}) - $signed({1'b0, q.acc});
		if (ce && tick) begin
			if (bypass) d.acc = {target, 16'h0000};
			else d.acc = q.acc + 32'(diff >>> shift);
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_b) q <= '0;
		else q <= d;
	end
	assign level = q.acc[31:16];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	bypass_load_a: assert property (ce && tick && bypass |=> level == $past(target))
		else $error("bypassed gain did not load target");
	lag_rise_a: assert property (ce && tick && !bypass && target > level
		|=> level <= $past(target) && level >= $past(level))
		else $error("rising gain left the lag band");
endmodule : gain_lag_filter

/* File: design/servo_gain_set_selector.sv */
// servo_gain_set_selector: register file, control tick, gain set switching
// assumes monitored quantities and pins synchronous to mclk
// Operation
// - signal source follows signal, polarity inverts
// - sources 2-4 compare at-or-above or at-or-below
// - direction source: negative or positive command
// - first threshold levels the first switch
// - same-condition second switch uses second threshold
// - thresholds in each quantity's native units
// - gains pass first-order lag with time constant
// - three whole gain sets substituted together
// - eight vibration parameters switch as well
// - base set active when nothing holds
// - switched sets use dedicated position gains
// - switched sets use dedicated speed gains
// - second set wins when both hold
// - zero second threshold blocks same-condition second set unless the first source is signal
// - disable field bypasses lag on switch/return
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
module servo_gain_set_selector #(
	parameter int CTRL_PERIOD_NS = gain_switch_pkg::CTRL_PERIOD_NS
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	input gain_switch_pkg::reg_req_t reg_req,
	output logic [gain_switch_pkg::DW-1:0] rdata,
	input gain_switch_pkg::monitor_t mon,
	input wire logic switch1_input,
	input wire logic switch2_input,
	output gain_switch_pkg::gain_set_t active_gains,
	output gain_switch_pkg::set_t active_set,
	output logic sw1_status,
	output logic sw2_status
);
	import gain_switch_pkg::*;

	localparam int CTRL_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICKS_PER_MS = NS_PER_MS / CTRL_PERIOD_NS;

	// whole state of the selector
	typedef struct packed {
		cfg_t cfg;
		thr_t thr1;
		thr_t thr2;
		logic [15:0] tc1;
		logic [15:0] tc2;
		logic switch1_command_bit;
		logic switch2_command_bit;
		gain_set_t [NSET-1:0] gain;
		set_t sel;
		set_t from;
		logic [CNTW-1:0] cnt;
		logic tick;
		logic [DW-1:0] rdata;
	} sel_state_t;

	// decoded gain table address
	typedef struct packed {
		logic hit;
		logic [1:0] set;
		logic [3:0] idx;
	} gain_addr_t;

	sel_state_t q, d;
	set_t eval_sel;
	logic [4:0] shift;
	logic bypass;
	gain_addr_t wa, ra;

	// decode an address inside one of the three gain tables
	function automatic gain_addr_t gain_decode(logic [7:0] a);
		gain_addr_t r;
		r.set = 2'(a[7:4] - GAIN_SET_NIB);
		r.idx = a[3:0];
		r.hit = (a[7:4] >= GAIN_SET_NIB) && (a[7:4] < GAIN_SET_NIB + 4'(NSET)) &&
			(a[3:0] < 4'(NGAIN));
		return r;
	endfunction : gain_decode

	// lag step: log2 of the time constant counted in control cycles
	function automatic logic [4:0] tc_shift(logic [15:0] tc);
		logic [31:0] t;
		t = 32'(tc) * 32'(TICKS_PER_MS);
		tc_shift = 5'h00;
		for (int i = 1; i < 32; i++) begin
			if (t[i]) tc_shift = 5'(i);
		end
	endfunction : tc_shift

	assign wa = gain_decode(reg_req.addr);
	assign ra = wa;

	// condition evaluation against thresholds and signals
	switch_condition_eval u_eval (
		.cfg(q.cfg),
		.thr1(q.thr1),
		.thr2(q.thr2),
		.mon(mon),
		.sig1(switch1_input | q.switch1_command_bit),
		.sig2(switch2_input | q.switch2_command_bit),
		.sel(eval_sel)
	);

	// time constant follows the switched set on either side of the move
	always_comb begin
		if (q.sel == SET_SW2 || q.from == SET_SW2) shift = tc_shift(q.tc2);
		else shift = tc_shift(q.tc1);
		case (q.cfg.time_constant_disable_select)
			TCD_AT_SWITCH: bypass = (q.sel != SET_BASE);
			TCD_AT_RETURN: bypass = (q.sel == SET_BASE);
			default: bypass = 1'b0;
		endcase
	end

	// one lag filter per gain, fed from the whole active set
	for (genvar g = 0; g < NGAIN; g++) begin : g_lag
		gain_lag_filter u_lag (
			.mclk(mclk),
			.rst_b(rst_b),
			.ce(ce),
			.tick(q.tick),
			.target(q.gain[q.sel][g]),
			.shift(shift),
			.bypass(bypass),
			.level(active_gains[g])
		);
	end

	// next state: tick counter, register writes and reads, set update
	always_comb begin
		d = q;
		if (ce) begin
			// control cycle tick
			if (q.cnt == CNTW'(CTRL_CYCLES - 1)) begin
				d.cnt = '0;
				d.tick = 1'b1;
			end else begin
				d.cnt = q.cnt + 1'b1;
				d.tick = 1'b0;
			end
			// register writes
			if (reg_req.wr) begin
				case (reg_req.addr)
					ADDR_CFG: d.cfg = cfg_t'(reg_req.wdata[19:0]);
					ADDR_THR1: d.thr1 = reg_req.wdata[15:0];
					ADDR_THR2: d.thr2 = reg_req.wdata[15:0];
					ADDR_TC1: d.tc1 = reg_req.wdata[15:0];
					ADDR_TC2: d.tc2 = reg_req.wdata[15:0];
					ADDR_CMD: begin
						d.switch1_command_bit = reg_req.wdata[0];
						d.switch2_command_bit = reg_req.wdata[1];
					end
					default: begin
						if (wa.hit) d.gain[wa.set][wa.idx] = reg_req.wdata[GW-1:0];
					end
				endcase
			end
			// register reads, data in the following cycle
			if (reg_req.rd) begin
				case (reg_req.addr)
					ADDR_CFG: d.rdata = DW'(q.cfg);
					ADDR_THR1: d.rdata = DW'(q.thr1);
					ADDR_THR2: d.rdata = DW'(q.thr2);
					ADDR_TC1: d.rdata = DW'(q.tc1);
					ADDR_TC2: d.rdata = DW'(q.tc2);
					ADDR_CMD: d.rdata = DW'({q.switch2_command_bit, q.switch1_command_bit});
					ADDR_STATUS: d.rdata = DW'({q.from, q.sel});
					default: begin
						if (ra.hit) d.rdata = DW'(q.gain[ra.set][ra.idx]);
						else d.rdata = '0;
					end
				endcase
			end
			// take the evaluated set once per control cycle
			if (q.tick && eval_sel != q.sel) begin
				d.from = q.sel;
				d.sel = eval_sel;
			end
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			q <= '0;
			q.cfg <= CFG_RST;
			q.thr1 <= THR_RST;
			q.thr2 <= THR_RST;
			q.tc1 <= TC_RST;
			q.tc2 <= TC_RST;
			q.gain <= {(NSET * NGAIN){GAIN_RST}};
			q.sel <= SET_BASE;
			q.from <= SET_BASE;
		end else begin
			q <= d;
		end
	end

	// outputs
	assign rdata = q.rdata;
	assign active_set = q.sel;
	assign sw1_status = (q.sel == SET_SW1);
	assign sw2_status = (q.sel == SET_SW2);

	// checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sig_polarity_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_SIG &&
		q.cfg.switch2_source_select == SRC2_OFF &&
		((switch1_input | q.switch1_command_bit) ^ q.cfg.switch_condition_polarity[0])
		|=> active_set == SET_SW1)
		else $error("signal source did not select first set");

	speed_thresh_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_SPEED &&
		!q.cfg.switch_condition_polarity[0] && q.cfg.switch2_source_select == SRC2_OFF &&
		qty_mag(mon.speed) >= q.thr1
		|=> active_set == SET_SW1)
		else $error("speed at threshold did not select first set");

	droop_below_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_DROOP &&
		q.cfg.switch_condition_polarity[0] && q.cfg.switch2_source_select == SRC2_OFF &&
		qty_mag(mon.droop) > q.thr1
		|=> active_set == SET_BASE)
		else $error("droop above threshold left base set");

	dir_negative_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_DIR &&
		!q.cfg.switch_condition_polarity[0] && q.cfg.switch2_source_select == SRC2_OFF
		|=> active_set == ($past(mon.dir_neg) ? SET_SW1 : SET_BASE))
		else $error("direction source chose wrong set");

	second_thresh_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_FREQ &&
		!q.cfg.switch_condition_polarity[0] && q.cfg.switch2_source_select == SRC2_SAME &&
		q.thr2 != 16'h0000 && qty_mag(mon.cmd_freq) >= q.thr2
		|=> active_set == SET_SW2)
		else $error("second threshold did not select second set");

	zero_second_a: assert property (
		ce && q.tick && q.cfg.switch2_source_select == SRC2_SAME &&
		q.cfg.switch1_source_select != SRC1_SIG && q.thr2 == 16'h0000
		|=> active_set != SET_SW2)
		else $error("zero second threshold reached second set");

	second_prio_a: assert property (
		ce && q.tick && q.cfg.switch2_source_select == SRC2_SIG &&
		(switch2_input | q.switch2_command_bit)
		|=> active_set == SET_SW2 && sw2_status && !sw1_status)
		else $error("second set lost priority");

	base_idle_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_OFF &&
		q.cfg.switch2_source_select == SRC2_OFF
		|=> active_set == SET_BASE)
		else $error("base set not used with switching off");

	gain_subst_a: assert property (
		ce && q.tick && q.cfg.time_constant_disable_select == TCD_AT_SWITCH &&
		q.sel != SET_BASE
		|=> active_gains == $past(q.gain[q.sel]))
		else $error("switched gain set not substituted whole");

	tick_spacing_a: assert property (
		ce && q.tick |=> !q.tick)
		else $error("control tick longer than one cycle");

	reg_read_a: assert property (
		ce && reg_req.rd && reg_req.addr == ADDR_CFG |=> rdata == DW'($past(q.cfg)))
		else $error("configuration read back wrong");

	// holding between ticks and under a low enable
	sel_hold_a: assert property (!(ce && q.tick) |=> $stable(active_set))
		else $error("active set moved between ticks");

	gains_hold_a: assert property (!(ce && q.tick) |=> $stable(active_gains))
		else $error("active gains moved between ticks");

	ce_freeze_a: assert property (!ce |=> $stable(q))
		else $error("state moved with enable low");

	// threshold and direction cases not covered above
	speed_below_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_SPEED &&
		q.cfg.switch_condition_polarity[0] && q.cfg.switch2_source_select == SRC2_OFF &&
		qty_mag(mon.speed) <= q.thr1
		|=> active_set == SET_SW1)
		else $error("speed at or below threshold did not select first set");

	freq_below_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_FREQ &&
		!q.cfg.switch_condition_polarity[0] && q.cfg.switch2_source_select == SRC2_OFF &&
		qty_mag(mon.cmd_freq) < q.thr1
		|=> active_set == SET_BASE)
		else $error("frequency below threshold left base set");

	dir_positive_a: assert property (
		ce && q.tick && q.cfg.switch1_source_select == SRC1_DIR &&
		q.cfg.switch_condition_polarity[0] && q.cfg.switch2_source_select == SRC2_OFF
		|=> active_set == ($past(mon.dir_pos) ? SET_SW1 : SET_BASE))
		else $error("positive direction chose wrong set");

	// second switch on the same condition as the first, and base gains loaded on return with lag bypass
	same_signal_a: assert property (
		ce && q.tick && q.cfg.switch2_source_select == SRC2_SAME &&
		q.cfg.switch1_source_select == SRC1_SIG && (switch2_input | q.switch2_command_bit)
		|=> active_set == SET_SW2)
		else $error("second signal on same condition lost");

	dir_second_a: assert property (
		ce && q.tick && q.cfg.switch2_source_select == SRC2_SAME &&
		q.cfg.switch1_source_select == SRC1_DIR && !q.cfg.switch_condition_polarity[0] &&
		q.thr2 != 16'h0000 && mon.dir_neg
		|=> active_set == SET_SW2)
		else $error("direction did not reach second set");

	return_load_a: assert property (
		ce && q.tick && q.cfg.time_constant_disable_select == TCD_AT_RETURN &&
		q.sel == SET_BASE
		|=> active_gains == $past(q.gain[SET_BASE]))
		else $error("base gains not loaded on return");

	// register port landing and read back
	reg_write_a: assert property (
		ce && reg_req.wr && reg_req.addr == ADDR_THR1
		|=> q.thr1 == $past(reg_req.wdata[15:0]))
		else $error("threshold write did not land");

	status_read_a: assert property (
		ce && reg_req.rd && reg_req.addr == ADDR_STATUS
		|=> rdata == DW'({$past(q.from), $past(q.sel)}))
		else $error("status read back wrong");

	bypass_jump_c: cover property (ce && q.tick && bypass);
	base_to_sw2_c: cover property (active_set == SET_BASE ##1 active_set == SET_SW2);
	enter_sw1_c: cover property (active_set == SET_BASE ##1 active_set == SET_SW1);
	enter_sw2_c: cover property (active_set == SET_SW1 ##1 active_set == SET_SW2);
	return_base_c: cover property (active_set == SET_SW2 ##1 active_set == SET_BASE);
endmodule : servo_gain_set_selector

/* File: testbench/motion_ctl_model.sv */
// motion_ctl_model: controller side of the gain selector, register master and switch pins
// assumes the selector answers a read in the cycle after the strobe and never stalls
`timescale 1ns/100ps
module motion_ctl_model (
	input wire logic mclk,
	output gain_switch_pkg::reg_req_t reg_req,
	input wire logic [gain_switch_pkg::DW-1:0] rdata,
	output logic switch1_input,
	output logic switch2_input
);
	import gain_switch_pkg::*;
	// idle bus and released pins at time zero
	initial begin
		reg_req = '0;
		switch1_input = 1'b0;
		switch2_input = 1'b0;
	end
	// one-cycle write; address and data turn over once released
	task automatic wr(input logic [7:0] a, input logic [DW-1:0] d);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask : wr
	// one-cycle read; data taken at the edge after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [DW-1:0] d);
		@(posedge mclk);
		reg_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		reg_req <= '{addr: ~a, wdata: '1, wr: 1'b0, rd: 1'b0};
		@(posedge mclk);
		d = rdata;
	endtask : rd
	// switch pins change right after an edge
	task automatic set_pins(input logic a, input logic b);
		@(posedge mclk);
		switch1_input <= a;
		switch2_input <= b;
	endtask : set_pins
	// three gain sets; inertia kept equal to base since the load does not change
	task automatic load_sets();
		for (int s = 0; s < NSET; s++) begin
			for (int i = 0; i < NGAIN; i++) begin
				wr(8'(16 * (s + 1) + i), (i == 0) ? 32'h50 : 32'((s + 1) * 256 + i));
			end
		end
	endtask : load_sets
endmodule : motion_ctl_model

/* File: testbench/servo_gain_set_selector_bench.sv */
// servo_gain_set_selector_bench: directed scenarios for gain set selection and lag
// assumes a tick every 100 cycles with CTRL_PERIOD_NS of 800 and gains loaded by the model
`timescale 1ns/100ps
module servo_gain_set_selector_bench;
	import gain_switch_pkg::*;
	localparam int TICK = 100;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	monitor_t mon = '0;
	reg_req_t reg_req;
	logic [DW-1:0] rdata;
	logic switch1_input;
	logic switch2_input;
	gain_set_t active_gains;
	set_t active_set;
	logic sw1_status;
	logic sw2_status;
	int n_mismatch = 0;
	int compares = 0;
	// 125 MHz clock
	always #4 mclk = ~mclk;
	servo_gain_set_selector #(.CTRL_PERIOD_NS(800)) i_dut (.mclk(mclk), .rst_b(rst_b),
		.ce(ce), .reg_req(reg_req), .rdata(rdata), .mon(mon), .switch1_input(switch1_input),
		.switch2_input(switch2_input), .active_gains(active_gains), .active_set(active_set),
		.sw1_status(sw1_status), .sw2_status(sw2_status));
	motion_ctl_model i_ctl (.mclk(mclk), .reg_req(reg_req), .rdata(rdata),
		.switch1_input(switch1_input), .switch2_input(switch2_input));
	// verdict and end of run
	task automatic tally_and_finish();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// gain value the model loads for a set and index
	function automatic gain_t gexp(input set_t s, input int i);
		gexp = (i == 0) ? 16'h0050 : 16'((int'(s) + 1) * 256 + i);
	endfunction : gexp
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [DW-1:0] d;
		i_ctl.rd(a, d);
		check("register", d, exp);
	endtask : rdchk
	// three ticks: decision, then filters follow
	task automatic settle();
		repeat (3 * TICK + 10) @(posedge mclk);
	endtask : settle
	task automatic expect_set(input set_t s);
		logic [DW-1:0] d;
		settle();
		check("active_set", 32'(active_set), 32'(s));
		check("sw_status", {30'h0, sw2_status, sw1_status}, {30'h0, s == SET_SW2, s == SET_SW1});
		for (int i = 0; i < NGAIN; i++) check("gain", 32'(active_gains[i]), 32'(gexp(s, i)));
		i_ctl.rd(ADDR_STATUS, d);
		check("status", {30'h0, d[1:0]}, 32'(s));
	endtask : expect_set
	task automatic set_mon(input logic [3:0] src, input qty_t v);
		monitor_t m;
		m = '0;
		case (src)
		SRC1_FREQ: m.cmd_freq = v;
		SRC1_DROOP: m.droop = v;
		SRC1_SPEED: m.speed = v;
		default: m = '0;
		endcase
		@(posedge mclk);
		mon <= m;
	endtask : set_mon
	// reset values, unmapped place, frozen strobes
	task automatic t_regs();
		for (int a = 0; a < 7; a++) rdchk(8'(a), 32'h0);
		check("gain_rst", 32'(active_gains[5]), 32'h0);
		i_ctl.wr(ADDR_THR1, 32'h1234);
		rdchk(ADDR_THR1, 32'h1234);
		i_ctl.wr(8'h7f, 32'hffff);
		rdchk(8'h7f, 32'h0);
		i_ctl.wr(8'h50, 32'hffff);
		rdchk(8'h50, 32'h0);
		@(posedge mclk);
		ce <= 1'b0;
		i_ctl.wr(ADDR_THR1, 32'h0055);
		@(posedge mclk);
		ce <= 1'b1;
		rdchk(ADDR_THR1, 32'h1234);
	endtask : t_regs
	task automatic t_signal();
		for (int p = 0; p < 2; p++) begin
			i_ctl.wr(ADDR_CFG, 32'h1 | (32'(p) << 4));
			for (int v = 0; v < 2; v++) begin
				i_ctl.set_pins(v[0], 1'b0);
				expect_set((v != p) ? SET_SW1 : SET_BASE);
			end
		end
		i_ctl.set_pins(1'b0, 1'b0);
		i_ctl.wr(ADDR_CFG, 32'h1);
		i_ctl.wr(ADDR_CMD, 32'h1);
		expect_set(SET_SW1);
		i_ctl.wr(ADDR_CMD, 32'h0);
	endtask : t_signal
	task automatic t_levels();
		qty_t vals [3] = '{16'sd63, -16'sd64, 16'sd65};
		i_ctl.wr(ADDR_THR1, 32'h40);
		i_ctl.wr(ADDR_THR2, 32'h0);
		for (int s = 2; s <= 4; s++) begin
			for (int p = 0; p < 2; p++) begin
				i_ctl.wr(ADDR_CFG, 32'(s) | (32'(p) << 4));
				for (int k = 0; k < 3; k++) begin
					set_mon(4'(s), vals[k]);
					expect_set(((p == 0) ? (k > 0) : (k < 2)) ? SET_SW1 : SET_BASE);
				end
			end
		end
		set_mon(SRC1_OFF, 16'sd0);
	endtask : t_levels
	task automatic t_dir();
		monitor_t m;
		for (int p = 0; p < 2; p++) begin
			i_ctl.wr(ADDR_CFG, 32'h5 | (32'(p) << 4));
			for (int d = 0; d < 2; d++) begin
				m = '0;
				m.dir_neg = (d == 0);
				m.dir_pos = (d == 1);
				@(posedge mclk);
				mon <= m;
				expect_set(((d == 0) == (p == 0)) ? SET_SW1 : SET_BASE);
			end
		end
		set_mon(SRC1_OFF, 16'sd0);
	endtask : t_dir
	task automatic t_second();
		i_ctl.wr(ADDR_THR2, 32'h80);
		i_ctl.wr(ADDR_CFG, 32'h20002);
		set_mon(SRC1_FREQ, 16'sd128);
		expect_set(SET_SW2);
		set_mon(SRC1_FREQ, 16'sd100);
		expect_set(SET_SW1);
		i_ctl.wr(ADDR_THR2, 32'h0);
		set_mon(SRC1_FREQ, 16'sd128);
		expect_set(SET_SW1);
		set_mon(SRC1_OFF, 16'sd0);
		i_ctl.wr(ADDR_CFG, 32'h10001);
		i_ctl.set_pins(1'b1, 1'b1);
		expect_set(SET_SW2);
		i_ctl.set_pins(1'b0, 1'b0);
		i_ctl.wr(ADDR_CMD, 32'h2);
		expect_set(SET_SW2);
		i_ctl.wr(ADDR_CMD, 32'h0);
		expect_set(SET_BASE);
		i_ctl.wr(ADDR_CFG, 32'h20001);
		i_ctl.set_pins(1'b0, 1'b1);
		expect_set(SET_SW2);
		i_ctl.set_pins(1'b0, 1'b0);
		i_ctl.wr(ADDR_CFG, 32'h20005);
		@(posedge mclk);
		mon <= '{cmd_freq: 16'sd0, droop: 16'sd0, speed: 16'sd0, dir_neg: 1'b1, dir_pos: 1'b0};
		expect_set(SET_SW1);
		i_ctl.wr(ADDR_THR2, 32'h80);
		expect_set(SET_SW2);
		set_mon(SRC1_OFF, 16'sd0);
		expect_set(SET_BASE);
	endtask : t_second
	// lag with a 1 ms constant, then each bypass mode
	task automatic t_lag();
		i_ctl.wr(ADDR_CFG, 32'h1);
		i_ctl.wr(ADDR_TC1, 32'h1);
		i_ctl.set_pins(1'b1, 1'b0);
		settle();
		check("lag", 32'(active_gains[3] != gexp(SET_SW1, 3)), 32'h1);
		i_ctl.wr(ADDR_CFG, 32'h101);
		settle();
		check("bypass_sw", 32'(active_gains[3]), 32'(gexp(SET_SW1, 3)));
		i_ctl.wr(ADDR_CFG, 32'h201);
		i_ctl.set_pins(1'b0, 1'b0);
		settle();
		check("bypass_ret", 32'(active_gains[3]), 32'(gexp(SET_BASE, 3)));
		i_ctl.wr(ADDR_CFG, 32'h1);
		i_ctl.set_pins(1'b1, 1'b0);
		settle();
		check("lag", 32'(active_gains[3] != gexp(SET_SW1, 3)), 32'h1);
		i_ctl.wr(ADDR_TC1, 32'h0);
		expect_set(SET_SW1);
	endtask : t_lag
	// second reset in mid-run clears selection and registers
	task automatic t_rereset();
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		check("set_rst", 32'(active_set), 32'(SET_BASE));
		check("sw_rst", {30'h0, sw2_status, sw1_status}, 32'h0);
		check("gain_rst2", 32'(active_gains[3]), 32'h0);
		rdchk(ADDR_CFG, 32'h0);
	endtask : t_rereset
	// watchdog against a hang
	initial begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		t_regs();
		i_ctl.load_sets();
		t_signal();
		t_levels();
		t_dir();
		t_second();
		t_lag();
		t_rereset();
		tally_and_finish();
	end
endmodule : servo_gain_set_selector_bench
